// File: rtl/timer_event_cfg.svh
// Bit positions, reset values and channel counts of the timer event flag block.
`ifndef TIMER_EVENT_CFG_SVH
`define TIMER_EVENT_CFG_SVH

`define CHANNEL_COUNT    5
`define DMA_CHANNELS     4
`define CHAN_SEL_W       3
`define FLAG_W           3
`define BIT_WRAP         2
`define BIT_B            1
`define BIT_A            0
`define STATUS_RESET     8'hF8
`define ENABLE_RESET     8'hF8
`define RESERVED_ONES    8'hF8
`define UNMAPPED_READ    8'hFF
`define SEL_STATUS       1'b0
`define SEL_ENABLE       1'b1
`define UPDOWN_CHANNEL   2
`define PWM_CHANNEL_LO   3
`define PWM_CHANNEL_HI   4

`endif

// File: rtl/timer_event_pkg.sv
// Types shared by the timer event flag block and its channel modules.
package timer_event_pkg;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] chan;
		logic       sel_enable;
		logic [7:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic wrap_up;
		logic wrap_down;
		logic match_a;
		logic capture_a;
		logic match_b;
		logic capture_b;
	} chan_event_type;

	typedef struct packed {
		logic a_is_capture;
		logic b_is_capture;
	} chan_cfg_type;

	typedef struct packed {
		logic wrap;
		logic b;
		logic a;
	} flag_set_type;

endpackage : timer_event_pkg

// File: rtl/event_status_channel.sv
// One channel's three sticky event flags with read-then-write-zero clearing.
`timescale 1ns/1ns
`default_nettype none
`include "timer_event_cfg.svh"

module event_status_channel (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        standby,
	input  wire timer_event_pkg::flag_set_type set,
	input  wire logic                        rd_hit,
	input  wire logic                        wr_hit,
	input  wire logic [`FLAG_W-1:0]          wdata,
	input  wire logic                        dma_clear,
	output logic      [`FLAG_W-1:0]          flags,
	output logic      [`FLAG_W-1:0]          next_flags
);

	logic [`FLAG_W-1:0] armed;

	// A new event in the clearing cycle wins, so no event is lost.
	always_comb begin
		next_flags = flags;
		if (wr_hit) begin
			next_flags = flags & ~(armed & ~wdata);
		end
		if (dma_clear) begin
			next_flags[`BIT_A] = 1'b0;
		end
		next_flags = next_flags | set;
	end

	always_ff @(posedge clk) begin
		if (!nrst || standby) begin
			flags <= 3'h0;
		end else begin
			flags <= next_flags;
		end
	end

	// A bit is armed only by a read that saw it at 1; a flag cleared some
	// other way disarms it, so a later event cannot be wiped by a stale read.
	always_ff @(posedge clk) begin
		if (!nrst || standby) begin
			armed <= 3'h0;
		end else if (rd_hit) begin
			armed <= flags;
		end else if (wr_hit) begin
			armed <= 3'h0;
		end else begin
			armed <= armed & next_flags;
		end
	end

endmodule : event_status_channel
`default_nettype wire

// File: rtl/irq_enable_channel.sv
// One channel's three interrupt enable bits.
`timescale 1ns/1ns
`default_nettype none
`include "timer_event_cfg.svh"

module irq_enable_channel (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 standby,
	input  wire logic                 wr_hit,
	input  wire logic [`FLAG_W-1:0]   wdata,
	output logic      [`FLAG_W-1:0]   en,
	output logic      [`FLAG_W-1:0]   next_en
);

	always_comb begin
		next_en = wr_hit ? wdata : en;
	end

	always_ff @(posedge clk) begin
		if (!nrst || standby) begin
			en <= 3'h0;
		end else begin
			en <= next_en;
		end
	end

endmodule : irq_enable_channel
`default_nettype wire

// File: rtl/timer_event_flags_irq.sv
// Event flags and interrupt enables of a five-channel timer, with CPU register access.
`timescale 1ns/1ns
`default_nettype none
`include "timer_event_cfg.svh"

module timer_event_flags_irq (
	input  wire logic                                   clk,
	input  wire logic                                   nrst,
	input  wire logic                                   standby,
	input  wire timer_event_pkg::reg_req_type           req,
	output logic      [7:0]                             rdata,
	input  wire timer_event_pkg::chan_event_type [4:0]  events,
	input  wire timer_event_pkg::chan_cfg_type   [4:0]  cfg,
	input  wire logic                                   phase_count_sel,
	input  wire logic                                   combo_mode_hi,
	input  wire logic                                   combo_mode_lo,
	input  wire logic [`DMA_CHANNELS-1:0]               dma_start_a,
	output logic      [`CHANNEL_COUNT-1:0]              wrap_irq,
	output logic      [`CHANNEL_COUNT-1:0]              event_a_irq,
	output logic      [`CHANNEL_COUNT-1:0]              event_b_irq
);

	logic [`FLAG_W-1:0]        flags      [`CHANNEL_COUNT];
	logic [`FLAG_W-1:0]        next_flags [`CHANNEL_COUNT];
	logic [`FLAG_W-1:0]        en         [`CHANNEL_COUNT];
	logic [`FLAG_W-1:0]        next_en    [`CHANNEL_COUNT];
	logic [`CHANNEL_COUNT-1:0] st_rd;
	logic [`CHANNEL_COUNT-1:0] st_wr;
	logic [`CHANNEL_COUNT-1:0] en_wr;
	logic [`CHANNEL_COUNT-1:0] updown;
	logic [`CHANNEL_COUNT-1:0] dma_clr;

	// Only channel 2 in phase counting and channels 3-4 in complementary
	// PWM run as up/down counters; a down wrap elsewhere is a datapath
	// glitch and is ignored rather than trusted.
	function automatic logic updown_ok(input int idx, input logic pcs,
			input logic hi, input logic lo);
		if (idx == `UPDOWN_CHANNEL) begin
			return pcs;
		end else if (idx == `PWM_CHANNEL_LO || idx == `PWM_CHANNEL_HI) begin
			return hi & ~lo;
		end
		return 1'b0;
	endfunction : updown_ok

	// Selects the setting source of flags A and B from the register function; the wrap flag also takes down wraps in up/down mode.
	function automatic timer_event_pkg::flag_set_type flag_set(
			input timer_event_pkg::chan_event_type ev,
			input timer_event_pkg::chan_cfg_type c,
			input logic ud);
		timer_event_pkg::flag_set_type s;
		s.wrap = ev.wrap_up | (ud & ev.wrap_down);
		s.b    = c.b_is_capture ? ev.capture_b : ev.match_b;
		s.a    = c.a_is_capture ? ev.capture_a : ev.match_a;
		return s;
	endfunction : flag_set

	// Each channel holds one status and one enable register.
	genvar i;
	generate
		for (i = 0; i < `CHANNEL_COUNT; i++) begin : g_chan
			logic                          hit;
			timer_event_pkg::flag_set_type set_now;

			assign hit        = (req.chan == 3'(i));
			assign st_rd[i]   = req.rd & hit & (req.sel_enable == `SEL_STATUS);
			assign st_wr[i]   = req.wr & hit & (req.sel_enable == `SEL_STATUS);
			assign en_wr[i]   = req.wr & hit & (req.sel_enable == `SEL_ENABLE);
			assign updown[i]  = updown_ok(i, phase_count_sel, combo_mode_hi, combo_mode_lo);
			assign set_now    = flag_set(events[i], cfg[i], updown[i]);
			if (i < `DMA_CHANNELS) begin : g_dma
				assign dma_clr[i] = dma_start_a[i];
			end else begin : g_nodma
				assign dma_clr[i] = 1'b0;
			end

			event_status_channel u_status (
				.clk        (clk),
				.nrst       (nrst),
				.standby    (standby),
				.set        (set_now),
				.rd_hit     (st_rd[i]),
				.wr_hit     (st_wr[i]),
				.wdata      (req.wdata[`FLAG_W-1:0]),
				.dma_clear  (dma_clr[i]),
				.flags      (flags[i]),
				.next_flags (next_flags[i])
			);

			irq_enable_channel u_enable (
				.clk     (clk),
				.nrst    (nrst),
				.standby (standby),
				.wr_hit  (en_wr[i]),
				.wdata   (req.wdata[`FLAG_W-1:0]),
				.en      (en[i]),
				.next_en (next_en[i])
			);

			// Requests are built from next values so they track flag and
			// enable without a cycle of lag while still leaving a flop.
			always_ff @(posedge clk) begin
				if (!nrst || standby) begin
					wrap_irq[i]    <= 1'b0;
					event_b_irq[i] <= 1'b0;
					event_a_irq[i] <= 1'b0;
				end else begin
					wrap_irq[i]    <= next_flags[i][`BIT_WRAP] & next_en[i][`BIT_WRAP];
					event_b_irq[i] <= next_flags[i][`BIT_B] & next_en[i][`BIT_B];
					event_a_irq[i] <= next_flags[i][`BIT_A] & next_en[i][`BIT_A];
				end
			end

			wrap_set_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				events[i].wrap_up |=> flags[i][`BIT_WRAP])
				else $error("wrap flag not set after upward wrap");

			down_wrap_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				(events[i].wrap_down && !events[i].wrap_up && !flags[i][`BIT_WRAP])
				|=> (flags[i][`BIT_WRAP] == $past(updown[i])))
				else $error("down wrap handled against counting mode");

			cmp_b_set_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				(events[i].match_b && !cfg[i].b_is_capture) |=> flags[i][`BIT_B])
				else $error("flag B not set on compare match");

			cap_b_set_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				(events[i].capture_b && cfg[i].b_is_capture) |=> flags[i][`BIT_B])
				else $error("flag B not set on capture");

			cmp_a_set_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				(events[i].match_a && !cfg[i].a_is_capture) |=> flags[i][`BIT_A])
				else $error("flag A not set on compare match");

			cap_a_set_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				(events[i].capture_a && cfg[i].a_is_capture) |=> flags[i][`BIT_A])
				else $error("flag A not set on capture");

			wrap_clear_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				$fell(flags[i][`BIT_WRAP])
				|-> ($past(st_wr[i]) || $past(standby) || !$past(nrst)))
				else $error("wrap flag cleared without a write");

			b_clear_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				$fell(flags[i][`BIT_B])
				|-> ($past(st_wr[i]) || $past(standby) || !$past(nrst)))
				else $error("flag B cleared without a write");

			a_clear_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				$fell(flags[i][`BIT_A]) |-> ($past(st_wr[i]) || $past(dma_clr[i])
				|| $past(standby) || !$past(nrst)))
				else $error("flag A cleared without write or DMA start");

			dma_clear_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				(dma_clr[i] && !set_now.a)
				|=> !flags[i][`BIT_A])
				else $error("DMA start did not clear flag A");

			write_one_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				(st_wr[i] && req.wdata[2:0] == 3'h7 && !dma_clr[i])
				|=> (($past(flags[i]) & ~flags[i]) == 3'h0))
				else $error("writing ones cleared a flag");

			no_blind_clr_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				(st_wr[i] && !$past(st_rd[i]) && !dma_clr[i] && flags[i][`BIT_WRAP]
				&& !$past(flags[i][`BIT_WRAP]) && !st_rd[i])
				|=> flags[i][`BIT_WRAP])
				else $error("wrap flag cleared without prior read as one");

			en_write_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				en_wr[i] |=> (en[i] == $past(req.wdata[2:0])))
				else $error("enable register did not take written value");

			irq_gate_a: assert property (@(posedge clk) disable iff (!nrst || standby)
				(wrap_irq[i] == (flags[i][`BIT_WRAP] && en[i][`BIT_WRAP]))
				&& (event_b_irq[i] == (flags[i][`BIT_B] && en[i][`BIT_B]))
				&& (event_a_irq[i] == (flags[i][`BIT_A] && en[i][`BIT_A])))
				else $error("interrupt request differs from flag and enable");
		end
	endgenerate

	// Read data is returned on the edge after the read strobe and holds
	// until the next read; unmapped channel numbers read all ones.
	always_ff @(posedge clk) begin
		if (!nrst || standby) begin
			rdata <= `STATUS_RESET;
		end else if (req.rd) begin
			if (req.chan >= 3'(`CHANNEL_COUNT)) begin
				rdata <= `UNMAPPED_READ;
			end else if (req.sel_enable == `SEL_ENABLE) begin
				rdata <= `RESERVED_ONES | {5'h00, en[req.chan]};
			end else begin
				rdata <= `RESERVED_ONES | {5'h00, flags[req.chan]};
			end
		end
	end

	reserved_ones_a: assert property (@(posedge clk) disable iff (!nrst)
		rdata[7:3] == 5'h1F)
		else $error("reserved bits did not read as one");

	standby_init_a: assert property (@(posedge clk) disable iff (!nrst)
		standby |=> (rdata == `STATUS_RESET && wrap_irq == 5'h00
		&& event_a_irq == 5'h00 && event_b_irq == 5'h00))
		else $error("standby did not initialise the registers");

endmodule : timer_event_flags_irq
`default_nettype wire

// File: testbench/cpu_bus_model.sv
// Register bus master model standing in for the CPU core.
`timescale 1ns/1ns
`default_nettype none

module cpu_bus_model (
	input  wire logic                         clk,
	output var  timer_event_pkg::reg_req_type req,
	input  wire logic [7:0]                   rdata
);
	initial begin
		req = '0;
	end

	// Strobes drop to zero and the other released fields are inverted so a stale value can never pass for a live one.
	task automatic release_bus();
		req.rd = 1'b0;
		req.wr = 1'b0;
		req.chan = ~req.chan;
		req.sel_enable = ~req.sel_enable;
		req.wdata = ~req.wdata;
	endtask : release_bus

	task automatic bus_read(input logic [2:0] chan, input logic sel, output logic [7:0] data);
		@(posedge clk);
		#1;
		req.rd = 1'b1;
		req.chan = chan;
		req.sel_enable = sel;
		@(posedge clk);
		#1;
		data = rdata;
		release_bus();
	endtask : bus_read

	task automatic bus_write(input logic [2:0] chan, input logic sel, input logic [7:0] data);
		@(posedge clk);
		#1;
		req.wr = 1'b1;
		req.chan = chan;
		req.sel_enable = sel;
		req.wdata = data;
		@(posedge clk);
		#1;
		release_bus();
	endtask : bus_write
endmodule : cpu_bus_model

`default_nettype wire

// File: testbench/timer_event_flags_irq_test.sv
// Self-checking bench for the timer event flag and interrupt enable block.
`timescale 1ns/1ns
`default_nettype none
`include "timer_event_cfg.svh"

`define CHECK(what, exp, got) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("mismatch %s expected %h seen %h", what, exp, got); \
	end \
end

module timer_event_flags_irq_test;
	logic                                  clk;
	logic                                  nrst;
	logic                                  standby;
	timer_event_pkg::reg_req_type          req;
	logic [7:0]                            rdata;
	timer_event_pkg::chan_event_type [4:0] events;
	timer_event_pkg::chan_cfg_type   [4:0] cfg;
	logic                                  phase_count_sel;
	logic                                  combo_mode_hi;
	logic                                  combo_mode_lo;
	logic [`DMA_CHANNELS-1:0]              dma_start_a;
	logic [`CHANNEL_COUNT-1:0]             wrap_irq;
	logic [`CHANNEL_COUNT-1:0]             event_a_irq;
	logic [`CHANNEL_COUNT-1:0]             event_b_irq;
	logic [7:0]                            got;
	int                                    fail_count;
	int                                    check_count;
	int                                    cycles;

	timer_event_flags_irq u_timer_event_flags_irq (
		.clk(clk), .nrst(nrst), .standby(standby), .req(req), .rdata(rdata),
		.events(events), .cfg(cfg), .phase_count_sel(phase_count_sel),
		.combo_mode_hi(combo_mode_hi), .combo_mode_lo(combo_mode_lo),
		.dma_start_a(dma_start_a), .wrap_irq(wrap_irq), .event_a_irq(event_a_irq),
		.event_b_irq(event_b_irq)
	);

	cpu_bus_model u_cpu_bus_model (
		.clk(clk), .req(req), .rdata(rdata)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	// The whole run needs well under a thousand cycles; a hang ends here.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic rd_chk(input int ch, input logic sel, input logic [7:0] exp, input string what);
		u_cpu_bus_model.bus_read(3'(ch), sel, got);
		`CHECK(what, exp, got)
	endtask : rd_chk

	task automatic wr(input int ch, input logic sel, input logic [7:0] d);
		u_cpu_bus_model.bus_write(3'(ch), sel, d);
	endtask : wr

	task automatic pulse(input int ch, input logic [5:0] ev);
		@(posedge clk);
		#1;
		events[ch] = ev;
		@(posedge clk);
		#1;
		events[ch] = 6'h00;
	endtask : pulse

	function automatic logic [2:0] irq3(input int ch);
		return {wrap_irq[ch], event_b_irq[ch], event_a_irq[ch]};
	endfunction : irq3

	initial begin
		nrst = 1'b0;
		standby = 1'b0;
		events = '0;
		cfg = '0;
		phase_count_sel = 1'b0;
		combo_mode_hi = 1'b0;
		combo_mode_lo = 1'b0;
		dma_start_a = 4'h0;
		repeat (10) @(posedge clk);
		#1;
		nrst = 1'b1;
		for (int ch = 0; ch < 6; ch++) begin
			rd_chk(ch, 1'b0, (ch < 5) ? 8'hF8 : 8'hFF, "status reset");
			rd_chk(ch, 1'b1, (ch < 5) ? 8'hF8 : 8'hFF, "enable reset");
		end
		$display("test reset values done");
		for (int ch = 0; ch < 5; ch++) begin
			// Odd channels use capture so both setting paths of flags A and B are reached.
			cfg[ch] = (ch % 2) ? 2'b11 : 2'b00;
			pulse(ch, (ch % 2) ? 6'h25 : 6'h2A);
			`CHECK("irq masked", 3'h0, irq3(ch))
			rd_chk(ch, 1'b0, 8'hFF, "status set");
			wr(ch, 1'b0, 8'h07);
			wr(ch, 1'b0, 8'h00);
			rd_chk(ch, 1'b0, 8'hFF, "status kept");
			wr(ch, 1'b1, 8'h07);
			`CHECK("irq enabled", 3'h7, irq3(ch))
			rd_chk(ch, 1'b1, 8'hFF, "enable read");
			wr(ch, 1'b1, 8'h03);
			`CHECK("irq wrap off", 3'h3, irq3(ch))
			rd_chk(ch, 1'b0, 8'hFF, "status arm");
			wr(ch, 1'b0, 8'h00);
			`CHECK("irq cleared", 3'h0, irq3(ch))
			rd_chk(ch, 1'b0, 8'hF8, "status cleared");
		end
		$display("test flags and enables done");
		phase_count_sel = 1'b1;
		combo_mode_hi = 1'b1;
		pulse(0, 6'h10);
		rd_chk(0, 1'b0, 8'hF8, "down ignored");
		pulse(2, 6'h10);
		rd_chk(2, 1'b0, 8'hFC, "down phase");
		pulse(3, 6'h10);
		rd_chk(3, 1'b0, 8'hFC, "down pwm");
		combo_mode_lo = 1'b1;
		pulse(4, 6'h10);
		rd_chk(4, 1'b0, 8'hF8, "down other mode");
		$display("test wrap down done");
		pulse(0, 6'h08);
		`CHECK("irq a", 1'b1, event_a_irq[0])
		@(posedge clk);
		#1;
		dma_start_a = 4'h1;
		@(posedge clk);
		#1;
		dma_start_a = 4'h0;
		`CHECK("irq a dma", 1'b0, event_a_irq[0])
		rd_chk(0, 1'b0, 8'hF8, "dma clear");
		$display("test dma clear done");
		pulse(1, 6'h25);
		`CHECK("irq before standby", 3'h3, irq3(1))
		@(posedge clk);
		#1;
		standby = 1'b1;
		@(posedge clk);
		#1;
		standby = 1'b0;
		`CHECK("irq standby", 3'h0, irq3(1))
		rd_chk(1, 1'b0, 8'hF8, "status standby");
		rd_chk(1, 1'b1, 8'hF8, "enable standby");
		$display("test standby done");
		end_sim();
	end
endmodule : timer_event_flags_irq_test

`default_nettype wire
